// ===== rtl/fault_supervisor_pkg.sv
/*
 fault supervisor package: state struct, timing constants, channel count.
 assumes a 200 MHz system clock and comparator flags from the analog front end.
*/
package fault_supervisor_pkg;
    localparam int CHANNELS = 6;
    localparam int CLOCK_MHZ = 200;
    localparam int OPEN_DEGLITCH_NS = 4000;
    localparam int FAST_DEGLITCH_NS = 100;
    localparam int OPEN_DEGLITCH_CYCLES = (OPEN_DEGLITCH_NS * CLOCK_MHZ) / 1000;
    localparam int FAST_DEGLITCH_CYCLES = (FAST_DEGLITCH_NS * CLOCK_MHZ) / 1000;
    localparam int COUNT_WIDTH = 24;
    localparam int PROG_DELAY_RESET = 240;

    typedef struct packed {
        logic [1:0] open_sync;
        logic [1:0] over_sync;
        logic [1:0] therm_sync;
        logic [1:0] line_sync;
        logic [1:0] dim_sync;
        logic [1:0] supply_sync;
        logic [1:0] bright_sync;
        logic [1:0] dimsel_sync;
        logic [1:0] pwr_sync;
        logic [CHANNELS-1:0] open_s1;
        logic [CHANNELS-1:0] open_s2;
        logic [CHANNELS-1:0] gnd_s1;
        logic [CHANNELS-1:0] gnd_s2;
        logic dim_prev;
        logic strap_done;
        logic [CHANNELS-1:0] unused_ch;
        logic open_qual;
        logic [COUNT_WIDTH-1:0] open_glitch;
        logic [COUNT_WIDTH-1:0] fast_glitch;
        logic [COUNT_WIDTH-1:0] open_delay;
        logic [COUNT_WIDTH-1:0] fast_delay;
        logic open_fault;
        logic fast_fault;
        logic [CHANNELS-1:0] open_ch;
        logic fault_oe;
        logic [CHANNELS-1:0] chan_en;
    } state_type;
endpackage : fault_supervisor_pkg

// ===== rtl/led_fault_supervisor.sv
/*
 fault supervision for a six channel current sink: open, overcurrent, thermal.
 assumes comparator flags are asynchronous levels; the open-drain line is resolved outside.
*/
`timescale 1ns/100ps

module led_fault_supervisor #(
    parameter int PROG_DELAY_CYCLES = fault_supervisor_pkg::PROG_DELAY_RESET
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [fault_supervisor_pkg::CHANNELS-1:0] open_low,
    input wire logic [fault_supervisor_pkg::CHANNELS-1:0] tied_ground,
    input wire logic over_current,
    input wire logic over_temp,
    input wire logic dimming_pwm,
    input wire logic supply_sense_gate,
    input wire logic bright_select,
    input wire logic dim_select,
    input wire logic power_good,
    input wire logic fault_line_n_in,
    output logic fault_line_n_out,
    output logic fault_line_n_oe,
    output logic [fault_supervisor_pkg::CHANNELS-1:0] channel_enable
);
    localparam int N = fault_supervisor_pkg::CHANNELS;
    localparam int W = fault_supervisor_pkg::COUNT_WIDTH;
    localparam logic [W-1:0] OPEN_LIM = W'(fault_supervisor_pkg::OPEN_DEGLITCH_CYCLES);
    localparam logic [W-1:0] FAST_LIM = W'(fault_supervisor_pkg::FAST_DEGLITCH_CYCLES);
    localparam logic [W-1:0] PROG_LIM = W'(PROG_DELAY_CYCLES);

    fault_supervisor_pkg::state_type state_ff;
    fault_supervisor_pkg::state_type nxt_state;

    // saturating counter that restarts when its condition drops
    function automatic logic [W-1:0] step(input logic cond, input logic [W-1:0] cnt, input logic [W-1:0] lim);
        if (!cond) begin
            step = '0;
        end else if (cnt < lim) begin
            step = cnt + W'(1);
        end else begin
            step = cnt;
        end
    endfunction : step

    // channel mask: shutdown causes first, then the open-LED hold, then normal running
    function automatic logic [N-1:0] gate_channels(
        input logic run,
        input logic shut,
        input logic hold_open,
        input logic [N-1:0] open_set,
        input logic [N-1:0] unused
    );
        if (!run || shut) begin
            gate_channels = '0;
        end else if (hold_open) begin
            gate_channels = open_set;
        end else begin
            gate_channels = ~unused;
        end
    endfunction : gate_channels

    logic active;
    logic line_low;
    logic open_any;
    logic open_seen;
    logic dim_fall;
    logic open_glitch_ok;
    logic fast_glitch_ok;
    logic fast_cause;
    logic open_delay_ok;
    logic fast_delay_ok;
    logic any_fault;
    logic [N-1:0] open_mask;

    always_comb begin
        nxt_state = state_ff;
        active = 1'b0;
        line_low = 1'b0;
        open_any = 1'b0;
        open_seen = 1'b0;
        dim_fall = 1'b0;
        open_glitch_ok = 1'b0;
        fast_glitch_ok = 1'b0;
        fast_cause = 1'b0;
        open_delay_ok = 1'b0;
        fast_delay_ok = 1'b0;
        any_fault = 1'b0;
        open_mask = '0;

        // every asynchronous pin passes two flops before anything reads it
        // open_sync is a settle marker: ones shift in after reset release
        nxt_state.open_sync = {state_ff.open_sync[0], 1'b1};
        nxt_state.over_sync = {state_ff.over_sync[0], over_current};
        nxt_state.therm_sync = {state_ff.therm_sync[0], over_temp};
        nxt_state.line_sync = {state_ff.line_sync[0], fault_line_n_in};
        nxt_state.dim_sync = {state_ff.dim_sync[0], dimming_pwm};
        nxt_state.supply_sync = {state_ff.supply_sync[0], supply_sense_gate};
        nxt_state.bright_sync = {state_ff.bright_sync[0], bright_select};
        nxt_state.dimsel_sync = {state_ff.dimsel_sync[0], dim_select};
        nxt_state.pwr_sync = {state_ff.pwr_sync[0], power_good};
        nxt_state.open_s1 = open_low;
        nxt_state.open_s2 = state_ff.open_s1;
        nxt_state.gnd_s1 = tied_ground;
        nxt_state.gnd_s2 = state_ff.gnd_s1;
        nxt_state.dim_prev = state_ff.dim_sync[1];

        // either brightness condition with power present keeps the circuit live
        active = state_ff.pwr_sync[1]
            && (state_ff.bright_sync[1] || state_ff.dimsel_sync[1]);
        line_low = !state_ff.line_sync[1];
        dim_fall = state_ff.dim_prev && !state_ff.dim_sync[1];

        // ground straps caught once, after reset release, from synchronised levels
        // wait until the strap synchroniser holds a real sample, not its reset zero
        if (!state_ff.strap_done && state_ff.open_sync[1]) begin
            nxt_state.strap_done = 1'b1;
            nxt_state.unused_ch = state_ff.gnd_s2;
        end

        open_mask = state_ff.open_s2 & ~state_ff.unused_ch;
        open_any = |open_mask;
        // supply gate comparator carries its own hysteresis
        open_seen = open_any && state_ff.supply_sync[1];

        // dimmed mode only updates the qualified open flag at the dimming falling edge
        if (state_ff.bright_sync[1]) begin
            nxt_state.open_qual = open_seen;
        end else if (dim_fall) begin
            nxt_state.open_qual = open_seen;
        end
        if (!active) begin
            nxt_state.open_qual = 1'b0;
        end

        // deglitch stage: open faults take the long interval, the fast causes the short one
        fast_cause = state_ff.over_sync[1] || state_ff.therm_sync[1];
        nxt_state.open_glitch = step(
            state_ff.open_qual && active,
            state_ff.open_glitch,
            OPEN_LIM
        );
        nxt_state.fast_glitch = step(
            fast_cause && active,
            state_ff.fast_glitch,
            FAST_LIM
        );
        open_glitch_ok = state_ff.open_glitch >= OPEN_LIM;
        fast_glitch_ok = state_ff.fast_glitch >= FAST_LIM;

        // programmable stage restarts from zero whenever its deglitched cause drops
        nxt_state.open_delay = step(
            open_glitch_ok,
            state_ff.open_delay,
            PROG_LIM
        );
        nxt_state.fast_delay = step(
            fast_glitch_ok,
            state_ff.fast_delay,
            PROG_LIM
        );
        open_delay_ok = state_ff.open_delay >= PROG_LIM;
        fast_delay_ok = state_ff.fast_delay >= PROG_LIM;
        nxt_state.open_fault = open_glitch_ok && open_delay_ok;
        nxt_state.fast_fault = fast_glitch_ok && fast_delay_ok;

        // remember which channels were open when the qualified open flag first set
        if (!state_ff.open_qual) begin
            nxt_state.open_ch = '0;
        end else if (nxt_state.open_ch == '0) begin
            nxt_state.open_ch = open_mask;
        end

        // one pull for every cause; a powered-down circuit never holds the line
        any_fault = state_ff.open_fault || state_ff.fast_fault;
        if (!active) begin
            nxt_state.fault_oe = 1'b0;
        end else if (any_fault) begin
            nxt_state.fault_oe = 1'b1;
        end else begin
            nxt_state.fault_oe = 1'b0;
        end

        // channel gating
        nxt_state.chan_en = gate_channels(
            active,
            line_low || fast_cause,
            state_ff.open_qual,
            state_ff.open_ch,
            state_ff.unused_ch
        );
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // open drain: output value is always low, enable pulls the line
    assign fault_line_n_out = 1'b0;
    assign fault_line_n_oe = state_ff.fault_oe;
    assign channel_enable = state_ff.chan_en;
endmodule : led_fault_supervisor

// ===== testbench/shared_line_partner.sv
/* other driver on the shared fault line; assumes a pull-up on that line. */
`timescale 1ns/100ps
module shared_line_partner (
    input wire logic clock,
    input wire logic fault_req,
    input wire logic dut_oe,
    output logic line_n
);
    logic own_oe_ff;
    always_ff @(posedge clock) own_oe_ff <= fault_req;
    // wired low wins; a released line reads high through the pull-up
    assign line_n = !(own_oe_ff || dut_oe);
endmodule : shared_line_partner

// ===== testbench/fault_supervisor_props.sv
/* port assertions of the fault supervisor, bound at the foot; assumes one clock domain. */
`timescale 1ns/100ps
module fault_supervisor_props #(parameter int PROG_DELAY_CYCLES = 10) (
    input wire logic clock, resetn, over_current, over_temp, supply_sense_gate, bright_select, dim_select,
    input wire logic power_good, fault_line_n_in, fault_line_n_oe,
    input wire logic [5:0] open_low, tied_ground, channel_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // ten cycles of slack on the fast path and fifteen on the open path, for the input synchronisers
    localparam int OC_MAX = 30 + PROG_DELAY_CYCLES;
    localparam int OPEN_MAX = 815 + PROG_DELAY_CYCLES;
    AST_LINE_SHUT: assert property ((!fault_line_n_in)[*6] |-> channel_enable == '0) else $error("line ignored");
    AST_OC_OFF: assert property (over_current[*6] |-> channel_enable == '0) else $error("left on");
    AST_OT_OFF: assert property (over_temp[*6] |-> channel_enable == '0) else $error("left on");
    AST_SEL_CLEAR: assert property ((!bright_select && !dim_select)[*6] |-> !fault_line_n_oe) else $error("kept");
    AST_ONSET: assert property ($rose(over_current) && !over_temp && open_low == '0
        |-> ##1 (!fault_line_n_oe)[*8]) else $error("early");
    AST_OC_DELAY: assert property ($rose(over_current) && power_good && bright_select
        |-> ##[1:OC_MAX] (fault_line_n_oe || !over_current || !power_good)) else $error("late");
    AST_PWR_CLEAR: assert property ((!power_good)[*6] |-> !fault_line_n_oe && channel_enable == '0) else $error("no power");
    AST_OPEN_DELAY: assert property ($rose(|(open_low & ~tied_ground)) && bright_select && !dim_select && supply_sense_gate
        |-> ##[1:OPEN_MAX] (fault_line_n_oe || open_low == '0 || !bright_select)) else $error("late open");
    AST_NO_CAUSE: assert property ((!over_current && !over_temp && open_low == '0 && bright_select && !dim_select)[*8]
        |-> !fault_line_n_oe) else $error("stray");
    cover property ($rose(fault_line_n_oe) && over_current);
    cover property ($rose(fault_line_n_oe) && over_temp);
    cover property ($fell(fault_line_n_oe) && !bright_select);
endmodule : fault_supervisor_props
bind led_fault_supervisor fault_supervisor_props #(.PROG_DELAY_CYCLES(PROG_DELAY_CYCLES)) u_props (.*);

// ===== testbench/tb.sv
/* bench for the led fault supervisor; assumes its bound checker and the line partner. */
`timescale 1ns/100ps
module tb;
    logic clock = 1'h0, resetn = 1'h0, over_current = 1'h0, over_temp = 1'h0, supply_sense_gate = 1'h1;
    logic bright_select = 1'h1, dim_select = 1'h0, power_good = 1'h1, dimming_pwm = 1'h1, other_fault = 1'h0;
    logic fault_line_n_in, fault_line_n_out, fault_line_n_oe;
    logic [5:0] open_low = 6'h00, tied_ground = 6'h00, channel_enable;
    int num_errors = 0, n_checks = 0, cycles = 0;
    always #2.5 clock = ~clock;
    shared_line_partner u_other (.clock(clock), .fault_req(other_fault), .dut_oe(fault_line_n_oe),
        .line_n(fault_line_n_in));
    led_fault_supervisor #(.PROG_DELAY_CYCLES(10)) u_dut (.*);
    task step(input int n);
        repeat (n) @(posedge clock);
    endtask : step
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) num_errors++;
        if (seen !== exp) $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    endtask : check
    // bounded wait; returns on a rising edge so drives stay on the edge
    task expect_oe(input logic v);
        for (int i = 0; i < 2000 && fault_line_n_oe !== v; i++) @(negedge clock);
        check({7'h00, fault_line_n_oe}, {7'h00, v});
        @(posedge clock);
    endtask : expect_oe
    task t_fast(input logic temp);
        over_current <= !temp;
        over_temp <= temp;
        expect_oe(1'h1);
        over_current <= 1'h0;
        over_temp <= 1'h0;
        expect_oe(1'h0);
        step(6);
        #1 check({2'h0, channel_enable}, 8'h3F);
        step(1);
    endtask : t_fast
    task t_open;
        open_low <= 6'h04;
        step(700);
        #1 check({7'h00, fault_line_n_oe}, 8'h00);
        check({2'h0, channel_enable}, 8'h04);
        expect_oe(1'h1);
        bright_select <= 1'h0;
        expect_oe(1'h0);
        open_low <= 6'h00;
        bright_select <= 1'h1;
        step(900);
        #1 check({2'h0, channel_enable}, 8'h3F);
        step(1);
    endtask : t_open
    task t_dim;
        bright_select <= 1'h0;
        dim_select <= 1'h1;
        open_low <= 6'h04;
        step(900);
        #1 check({7'h00, fault_line_n_oe}, 8'h00);
        step(1);
        dimming_pwm <= 1'h0;
        expect_oe(1'h1);
        open_low <= 6'h00;
        dimming_pwm <= 1'h1;
        step(4);
        dimming_pwm <= 1'h0;
        expect_oe(1'h0);
        bright_select <= 1'h1;
        dim_select <= 1'h0;
        dimming_pwm <= 1'h1;
        step(8);
    endtask : t_dim
    task t_line;
        other_fault <= 1'h1;
        step(6);
        #1 check({2'h0, channel_enable}, 8'h00);
        check({7'h00, fault_line_n_oe}, 8'h00);
        step(1);
        other_fault <= 1'h0;
        step(6);
        #1 check({2'h0, channel_enable}, 8'h3F);
        step(1);
    endtask : t_line
    task t_power;
        over_current <= 1'h1;
        expect_oe(1'h1);
        power_good <= 1'h0;
        expect_oe(1'h0);
        over_current <= 1'h0;
        power_good <= 1'h1;
        step(8);
        #1 check({2'h0, channel_enable}, 8'h3F);
        step(1);
    endtask : t_power
    task t_strap;
        resetn <= 1'h0;
        tied_ground <= 6'h01;
        step(2);
        resetn <= 1'h1;
        step(6);
        #1 check({2'h0, channel_enable}, 8'h3E);
        step(1);
        supply_sense_gate <= 1'h0;
        open_low <= 6'h02;
        step(900);
        #1 check({7'h00, fault_line_n_oe}, 8'h00);
        step(1);
        supply_sense_gate <= 1'h1;
        open_low <= 6'h01;
        step(900);
        #1 check({7'h00, fault_line_n_oe}, 8'h00);
        check({2'h0, channel_enable}, 8'h3E);
        step(1);
        open_low <= 6'h00;
        resetn <= 1'h0;
        tied_ground <= 6'h00;
        step(2);
        resetn <= 1'h1;
        step(6);
    endtask : t_strap
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    always @(posedge clock) if (++cycles == 12000) num_errors++;
    always @(posedge clock) if (cycles == 12001) give_verdict;
    initial begin
        step(20);
        resetn <= 1'h1;
        t_fast(1'h0);
        t_fast(1'h1);
        t_open;
        t_dim;
        t_line;
        t_power;
        t_strap;
        give_verdict;
    end
endmodule : tb
